// ==== hdl/rqr_pkg.sv ====
/*
  Constants for the receive-queue readout block: register offsets, field
  positions, reset values and frame limits.
  Assumes a 16-bit register port with 12-bit byte offsets.
*/
`default_nettype none
package rqr_pkg;
  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  localparam int LEN_W = 12;
  localparam int HDR_W = DATA_W + LEN_W;
  localparam logic [11:0] OFS_HDR_STATUS = 12'h17c;
  localparam logic [11:0] OFS_HDR_LENGTH = 12'h17e;
  localparam logic [11:0] OFS_DATA_PORT = 12'h180;
  localparam logic [11:0] OFS_QUEUE_CTRL = 12'h182;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h190;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h192;
  localparam logic [11:0] OFS_TALLY = 12'h1b8;
  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int QCTRL_BYTE_MODE_BIT = 0;
  localparam int QCTRL_DMA_BIT = 3;
  localparam int IRQ_RX_BIT = 13;
  localparam int TALLY_LSB = 8;
  localparam logic [15:0] REG_RST = 16'h0000;
  localparam logic [15:0] CLEAR_ALL = 16'hffff;
  // ----------------------------------------------------------------
  // Frame limits
  // ----------------------------------------------------------------
  localparam logic [11:0] MAX_FRAME_BYTES = 12'h7d0;
  localparam logic [11:0] BYTES_PER_WORD = 12'h002;
endpackage
`default_nettype wire

// ==== hdl/rqr_fifo_if.sv ====
/*
  Bundle between the readout logic and one of its flip-flop queues.
  Assumes both ends share one clock.
*/
`default_nettype none
interface rqr_fifo_if #(
  parameter int W = 16,
  parameter int CW = 5
);
  logic push;
  logic [W-1:0] wdata;
  logic pop;
  logic [W-1:0] head;
  logic [CW-1:0] count;
  modport user (output push, output wdata, output pop, input head, input count);
  modport store (input push, input wdata, input pop, output head, output count);
endinterface
`default_nettype wire

// ==== hdl/rqr_queue.sv ====
/*
  Flip-flop queue of W-bit entries, D deep, head shown without a pop.
  Assumes D is a power of two; a push when full or a pop when empty is
  ignored.
*/
`default_nettype none
module rqr_queue #(
  parameter int W = 16,
  parameter int D = 16
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  rqr_fifo_if.store q
);
  localparam int PW = $clog2(D);
  localparam int CW = PW + 1;
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
  } rqr_queue_state_type;
  rqr_queue_state_type s_r;
  rqr_queue_state_type s_nxt;
  logic do_push;
  logic do_pop;

  // Guarded push and pop, count follows both
  always_comb begin
    s_nxt = s_r;
    do_push = q.push && (s_r.cnt != CW'(D));
    do_pop = q.pop && (s_r.cnt != '0);
    if (do_push) begin
      s_nxt.mem[s_r.wp] = q.wdata;
      s_nxt.wp = PW'(s_r.wp + 1'b1);
    end
    if (do_pop) begin
      s_nxt.rp = PW'(s_r.rp + 1'b1);
    end
    s_nxt.cnt = CW'(s_r.cnt + CW'(do_push) - CW'(do_pop));
  end

  // State register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q.head = s_r.mem[s_r.rp];
  assign q.count = s_r.cnt;
endmodule
`default_nettype wire

// ==== hdl/rqr_readout.sv ====
/*
  Receive-queue readout: frames from the receive side are queued as data
  words plus a header entry; the host pulls tally, headers and data over a
  16-bit register port and gets one level interrupt.
  Assumes receive-side inputs are on clk_in and register strobes are one
  cycle long, never together.
*/
`default_nettype none
module rqr_readout #(
  parameter int DATA_DEPTH = 1024,
  parameter int HDR_DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [rqr_pkg::ADDR_W-1:0] addr_in,
  input wire logic [rqr_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [rqr_pkg::DATA_W-1:0] rdata_out,
  output logic irq_out,
  input wire logic rxin_valid_in,
  input wire logic [rqr_pkg::DATA_W-1:0] rxin_data_in,
  input wire logic rxin_last_in,
  input wire logic [rqr_pkg::DATA_W-1:0] rxin_status_in,
  input wire logic [rqr_pkg::LEN_W-1:0] rxin_bytes_in,
  output logic rxin_ready_out
);
  localparam int DCW = $clog2(DATA_DEPTH) + 1;
  localparam int HCW = $clog2(HDR_DEPTH) + 1;
  typedef struct packed {
    logic [15:0] rdata;
    logic irq;
    logic ready;
    logic [15:0] irq_status_register;
    logic [15:0] ier;
    logic [15:0] qctrl;
    logic [7:0] tally;
    logic [15:0] hstat;
    logic [11:0] hlen;
    logic hs_rd;
    logic hl_rd;
    logic dummy_done;
    logic hi_byte;
    logic wodd;
    logic pad_pend;
    logic [11:0] rx_bytes;
  } rqr_state_type;
  rqr_state_type s_r;
  rqr_state_type s_nxt;
  logic frame_end;
  logic data_pushed;
  rqr_fifo_if #(.W(rqr_pkg::DATA_W), .CW(DCW)) dq ();
  rqr_fifo_if #(.W(rqr_pkg::HDR_W), .CW(HCW)) hq ();

  // ----------------------------------------------------------------
  // Queues: packet words and per-frame header entries
  // ----------------------------------------------------------------
  rqr_queue #(.W(rqr_pkg::DATA_W), .D(DATA_DEPTH)) u_data_q (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .q(dq.store)
  );
  rqr_queue #(.W(rqr_pkg::HDR_W), .D(HDR_DEPTH)) u_hdr_q (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .q(hq.store)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Register port, receive intake and interrupt in one pass
  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = '0;
    dq.push = 1'b0;
    dq.wdata = rxin_data_in;
    dq.pop = 1'b0;
    hq.push = 1'b0;
    hq.wdata = {rxin_status_in, rxin_bytes_in};
    hq.pop = 1'b0;
    frame_end = 1'b0;
    data_pushed = 1'b0;
    // Register writes
    if (wr_in) begin
      case (addr_in)
        rqr_pkg::OFS_IRQ_STATUS: begin
          s_nxt.irq_status_register = s_r.irq_status_register & ~wdata_in;
          if (wdata_in[rqr_pkg::IRQ_RX_BIT]) begin
            s_nxt.tally = 8'(hq.count);
          end
        end
        rqr_pkg::OFS_IRQ_MASK: s_nxt.ier = wdata_in;
        rqr_pkg::OFS_QUEUE_CTRL: begin
          s_nxt.qctrl = wdata_in;
          if (wdata_in[rqr_pkg::QCTRL_DMA_BIT] && !s_r.qctrl[rqr_pkg::QCTRL_DMA_BIT]) begin
            s_nxt.dummy_done = 1'b0;
            s_nxt.hi_byte = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // Register reads; unmapped offsets answer zero
    if (rd_in) begin
      case (addr_in)
        rqr_pkg::OFS_HDR_STATUS: begin
          s_nxt.rdata = s_r.hstat;
          s_nxt.hs_rd = 1'b1;
        end
        rqr_pkg::OFS_HDR_LENGTH: begin
          s_nxt.rdata = {4'h0, s_r.hlen};
          s_nxt.hl_rd = 1'b1;
        end
        rqr_pkg::OFS_TALLY: begin
          s_nxt.rdata = {s_r.tally, 8'h00};
          if (hq.count != '0) begin
            s_nxt.hstat = hq.head[rqr_pkg::HDR_W-1:rqr_pkg::LEN_W];
            s_nxt.hlen = hq.head[rqr_pkg::LEN_W-1:0];
            hq.pop = 1'b1;
            s_nxt.hs_rd = 1'b0;
            s_nxt.hl_rd = 1'b0;
          end
        end
        rqr_pkg::OFS_IRQ_STATUS: s_nxt.rdata = s_r.irq_status_register;
        rqr_pkg::OFS_IRQ_MASK: s_nxt.rdata = s_r.ier;
        rqr_pkg::OFS_QUEUE_CTRL: s_nxt.rdata = s_r.qctrl;
        rqr_pkg::OFS_DATA_PORT: begin
          if (s_r.qctrl[rqr_pkg::QCTRL_DMA_BIT]) begin
            if (!s_r.dummy_done) begin
              s_nxt.dummy_done = 1'b1;
            end else if (s_r.qctrl[rqr_pkg::QCTRL_BYTE_MODE_BIT]) begin
              // Low byte first, word leaves after its high byte
              s_nxt.rdata = {8'h00, s_r.hi_byte ? dq.head[15:8] : dq.head[7:0]};
              s_nxt.hi_byte = !s_r.hi_byte;
              dq.pop = s_r.hi_byte && (dq.count != '0);
            end else begin
              s_nxt.rdata = dq.head;
              dq.pop = dq.count != '0;
            end
          end
        end
        default: ;
      endcase
    end
    // both header halves read, move on
    if (s_nxt.hs_rd && s_nxt.hl_rd && !hq.pop) begin
      s_nxt.hs_rd = 1'b0;
      s_nxt.hl_rd = 1'b0;
      if (hq.count != '0) begin
        s_nxt.hstat = hq.head[rqr_pkg::HDR_W-1:rqr_pkg::LEN_W];
        s_nxt.hlen = hq.head[rqr_pkg::LEN_W-1:0];
        hq.pop = 1'b1;
      end
    end
    // Receive intake; pad word first if one is owed
    if (s_r.pad_pend) begin
      // queue ends frame on a double word
      dq.wdata = '0;
      dq.push = 1'b1;
      s_nxt.pad_pend = 1'b0;
    end else if (rxin_valid_in && s_r.ready) begin
      // words past the limit are dropped
      if (s_r.rx_bytes < rqr_pkg::MAX_FRAME_BYTES) begin
        dq.push = 1'b1;
        data_pushed = 1'b1;
        s_nxt.rx_bytes = 12'(s_r.rx_bytes + rqr_pkg::BYTES_PER_WORD);
      end
      s_nxt.wodd = s_r.wodd ^ data_pushed;
      if (rxin_last_in) begin
        frame_end = 1'b1;
        // header length capped at the limit
        if (rxin_bytes_in > rqr_pkg::MAX_FRAME_BYTES) begin
          hq.wdata = {rxin_status_in, rqr_pkg::MAX_FRAME_BYTES};
        end
        hq.push = 1'b1;
        s_nxt.pad_pend = s_nxt.wodd;
        s_nxt.wodd = 1'b0;
        s_nxt.rx_bytes = '0;
      end
    end
    // Frame arrival set wins over a same-cycle clear
    if (frame_end) begin
      s_nxt.irq_status_register[rqr_pkg::IRQ_RX_BIT] = 1'b1;
    end
    // Margins of three data words and two header entries cover the one-cycle lag of registered ready
    s_nxt.ready = (dq.count < DCW'(DATA_DEPTH - 3)) && (hq.count < HCW'(HDR_DEPTH - 2))
      && !s_nxt.pad_pend;
    s_nxt.irq = |(s_nxt.irq_status_register & s_nxt.ier);
  end

  // State register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_r <= '0;
      s_r.irq_status_register <= rqr_pkg::REG_RST;
      s_r.ier <= rqr_pkg::REG_RST;
      s_r.qctrl <= rqr_pkg::REG_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata_out = s_r.rdata;
  assign irq_out = s_r.irq;
  assign rxin_ready_out = s_r.ready;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic data_rd;
  assign data_rd = rd_in && (addr_in == rqr_pkg::OFS_DATA_PORT);
  sequence hs_then_hl_s;
    (rd_in && addr_in == rqr_pkg::OFS_HDR_STATUS && !s_r.hl_rd)
    ##1 !rd_in
    ##1 (rd_in && addr_in == rqr_pkg::OFS_HDR_LENGTH && hq.count != '0);
  endsequence

  dummy_zero_a: assert property (
    (data_rd && s_r.qctrl[rqr_pkg::QCTRL_DMA_BIT] && !s_r.dummy_done)
    |-> !dq.pop ##1 rdata_out == 16'h0000)
    else $error("dummy read popped data or returned nonzero");
  rx_clear_a: assert property (
    (wr_in && addr_in == rqr_pkg::OFS_IRQ_STATUS && wdata_in[rqr_pkg::IRQ_RX_BIT] && !frame_end)
    |=> !s_r.irq_status_register[rqr_pkg::IRQ_RX_BIT] && s_r.tally == 8'($past(hq.count)))
    else $error("rx clear did not clear bit or load tally");
  tally_header_a: assert property (
    (rd_in && addr_in == rqr_pkg::OFS_TALLY && hq.count != '0)
    |=> s_r.hlen == $past(hq.head[rqr_pkg::LEN_W-1:0]) && !s_r.hs_rd && !s_r.hl_rd)
    else $error("tally read did not load header");
  header_advance_a: assert property (
    hs_then_hl_s |=> s_r.hstat == $past(hq.head[rqr_pkg::HDR_W-1:rqr_pkg::LEN_W]))
    else $error("header did not advance after both reads");
  frame_limit_a: assert property (
    s_r.hlen <= rqr_pkg::MAX_FRAME_BYTES)
    else $error("header length above frame limit");
  stream_gate_a: assert property (
    dq.pop |-> s_r.dummy_done && s_r.qctrl[rqr_pkg::QCTRL_DMA_BIT] && data_rd)
    else $error("data popped outside an enabled burst");
  clear_all_a: assert property (
    (wr_in && addr_in == rqr_pkg::OFS_IRQ_STATUS && wdata_in == rqr_pkg::CLEAR_ALL && !frame_end)
    |=> s_r.irq_status_register == 16'h0000 && !irq_out)
    else $error("all-ones write left status set");
  length_field_a: assert property (
    (rd_in && addr_in == rqr_pkg::OFS_HDR_LENGTH) |=> rdata_out[15:12] == 4'h0)
    else $error("length read has upper bits set");
  pad_word_a: assert property (
    (frame_end && s_nxt.pad_pend) |=> dq.push && dq.wdata == 16'h0000 && !rxin_ready_out)
    else $error("odd frame not padded to double word");
  irq_follow_a: assert property (
    (|(s_r.irq_status_register & s_r.ier)) [*2] |-> irq_out)
    else $error("interrupt low with unmasked status");
endmodule
`default_nettype wire

// ==== testbench/rqr_frame_src.sv ====
/*
  Receive-side frame source that feeds the readout block's receive link.
  Assumes the block's ready output is registered on clk_in.
*/
`default_nettype none
module rqr_frame_src (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ready_in,
  output logic valid_out,
  output logic [rqr_pkg::DATA_W-1:0] data_out,
  output logic last_out,
  output logic [rqr_pkg::DATA_W-1:0] status_out,
  output logic [rqr_pkg::LEN_W-1:0] bytes_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Idle levels
  // ------------------------------------------------------------
  initial begin
    valid_out = 1'b0;
    data_out = 16'h0000;
    last_out = 1'b0;
    status_out = 16'h0000;
    bytes_out = 12'h000;
  end
  // ------------------------------------------------------------
  // Frame sender
  // ------------------------------------------------------------
  // one frame per call
  task automatic send(input logic [11:0] nbytes, input logic [15:0] stat,
                      input logic [15:0] base);
    int words;
    words = (int'(nbytes) + 1) / 2;
    @(posedge clk_in);
    for (int i = 0; i < words; i++) begin
      valid_out <= 1'b1;
      data_out <= base + 16'(i);
      last_out <= (i == words - 1);
      status_out <= stat;
      bytes_out <= nbytes;
      // Ready is registered, so its value before the edge is what the edge sees
      do @(negedge clk_in); while ((ready_in & rst_n_in) !== 1'b1);
      @(posedge clk_in);
    end
    valid_out <= 1'b0;
    last_out <= 1'b0;
    // Released lines flip so a stale word can never pass for a fresh one
    data_out <= ~data_out;
    status_out <= ~status_out;
    bytes_out <= ~bytes_out;
  endtask
endmodule
`default_nettype wire

// ==== testbench/rqr_readout_tb.sv ====
/*
  Self-checking bench for the receive-queue readout block.
  Assumes the host port of the notes: one-cycle strobes, data the cycle after.
*/
`default_nettype none
module rqr_readout_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0;
  logic rst_n_in, wr_in, rd_in, irq_out, valid, last, ready;
  logic [11:0] addr_in, nbytes;
  logic [15:0] wdata_in, rdata_out, data, status;
  int bad_count = 0;
  int checks_done = 0;
  // ------------------------------------------------------------
  // Clock, design and frame source
  // ------------------------------------------------------------
  always #5 clk_in = ~clk_in;
  rqr_readout dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .irq_out(irq_out), .rxin_valid_in(valid), .rxin_data_in(data),
    .rxin_last_in(last), .rxin_status_in(status), .rxin_bytes_in(nbytes),
    .rxin_ready_out(ready));
  rqr_frame_src src_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .ready_in(ready),
    .valid_out(valid), .data_out(data), .last_out(last), .status_out(status),
    .bytes_out(nbytes));
  // ------------------------------------------------------------
  // Host access tasks
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic reg_wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  // Read data lives for one cycle only, so it is taken just after that edge
  task automatic rd_chk(input string what, input logic [11:0] a, input logic [15:0] exp);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    check(what, rdata_out, exp);
  endtask
  task automatic rd_words(input logic [15:0] base, input int n, input int pads);
    for (int i = 0; i < n + pads; i++) begin
      rd_chk("data word", rqr_pkg::OFS_DATA_PORT, (i < n) ? base + 16'(i) : 16'h0000);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Watchdog: the tests need about 1100 cycles
  // ------------------------------------------------------------
  initial begin
    repeat (5000) @(posedge clk_in);
    bad_count++;
    wrap_up;
  end
  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    rst_n_in = 1'b0;
    wr_in = 1'b0;
    rd_in = 1'b0;
    addr_in = 12'h000;
    wdata_in = 16'h0000;
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd_chk("unmapped", 12'h000, 16'h0000);
    check("ready idle", {15'h0000, ready}, 16'h0001);
    rd_chk("data port idle", rqr_pkg::OFS_DATA_PORT, 16'h0000);
    rd_chk("mask reset", rqr_pkg::OFS_IRQ_MASK, rqr_pkg::REG_RST);
    src_u.send(12'h003, 16'h8001, 16'h1100);
    src_u.send(12'h005, 16'h8002, 16'h2200);
    rd_chk("status polled", rqr_pkg::OFS_IRQ_STATUS, 16'h2000);
    check("irq masked", {15'h0000, irq_out}, 16'h0000);
    reg_wr(rqr_pkg::OFS_IRQ_MASK, 16'h2000);
    rd_chk("mask", rqr_pkg::OFS_IRQ_MASK, 16'h2000);
    check("irq raised", {15'h0000, irq_out}, 16'h0001);
    reg_wr(rqr_pkg::OFS_IRQ_STATUS, 16'h2000);
    rd_chk("status cleared", rqr_pkg::OFS_IRQ_STATUS, 16'h0000);
    check("irq cleared", {15'h0000, irq_out}, 16'h0000);
    rd_chk("tally", rqr_pkg::OFS_TALLY, 16'h0200);
    rd_chk("status a", rqr_pkg::OFS_HDR_STATUS, 16'h8001);
    rd_chk("length a", rqr_pkg::OFS_HDR_LENGTH, 16'h0003);
    rd_chk("length b", rqr_pkg::OFS_HDR_LENGTH, 16'h0005);
    rd_chk("status b", rqr_pkg::OFS_HDR_STATUS, 16'h8002);
    reg_wr(rqr_pkg::OFS_QUEUE_CTRL, 16'h0008);
    rd_chk("dummy word", rqr_pkg::OFS_DATA_PORT, 16'h0000);
    rd_words(16'h1100, 2, 0);
    rd_words(16'h2200, 3, 1);
    src_u.send(12'h002, 16'h8003, 16'h33cc);
    reg_wr(rqr_pkg::OFS_IRQ_STATUS, rqr_pkg::CLEAR_ALL);
    rd_chk("status all", rqr_pkg::OFS_IRQ_STATUS, 16'h0000);
    rd_chk("tally c", rqr_pkg::OFS_TALLY, 16'h0100);
    rd_chk("status c", rqr_pkg::OFS_HDR_STATUS, 16'h8003);
    rd_chk("length c", rqr_pkg::OFS_HDR_LENGTH, 16'h0002);
    reg_wr(rqr_pkg::OFS_QUEUE_CTRL, 16'h0000);
    reg_wr(rqr_pkg::OFS_QUEUE_CTRL, 16'h0009);
    rd_chk("dummy byte", rqr_pkg::OFS_DATA_PORT, 16'h0000);
    rd_chk("low byte", rqr_pkg::OFS_DATA_PORT, 16'h00cc);
    rd_chk("high byte", rqr_pkg::OFS_DATA_PORT, 16'h0033);
    rd_words(16'h0000, 0, 2);
    src_u.send(12'h7d2, 16'h8004, 16'h4000);
    reg_wr(rqr_pkg::OFS_IRQ_STATUS, 16'h2000);
    rd_chk("tally d", rqr_pkg::OFS_TALLY, 16'h0100);
    rd_chk("length capped", rqr_pkg::OFS_HDR_LENGTH, {4'h0, rqr_pkg::MAX_FRAME_BYTES});
    rd_chk("status d", rqr_pkg::OFS_HDR_STATUS, 16'h8004);
    wrap_up;
  end
endmodule
`default_nettype wire
